// ===== sim/afc_flash_model.sv
`timescale 1ns/100ps
module afc_flash_model (
  // Pins from the host
  input wire logic [21:0] flash_addr,
  input wire logic flash_ce_n,
  input wire logic flash_oe_n,
  input wire logic flash_we_n,
  input wire logic reset_powerdown_n,
  input wire logic flash_byte_n,
  input wire logic [15:0] flash_dq_o,
  // Pins back to the host
  output logic [15:0] flash_dq_i,
  output logic rb_low
);
  logic [7:0] mode_r, pend_r, stat_r;
  logic [15:0] otp_r [256];
  logic armed;
  event start_busy;
  wire logic [7:0] oa = flash_addr[7:0];
  wire logic [15:0] word = mode_r == 8'h90 ? otp_r[oa] : mode_r == 8'h70 ? {8'h00, stat_r} : flash_addr[15:0] ^ 16'h5a5a;
  wire logic [15:0] rd_val = flash_byte_n ? word : {~word[15:8], word[7:0]};
  wire logic rd_en = !flash_ce_n && !flash_oe_n && reset_powerdown_n;
  initial
  begin
    foreach (otp_r[i]) otp_r[i] = 16'hffff;
    otp_r[128] = 16'hfffe;
    armed = 1'h0;
    rb_low = 1'h0;
    flash_dq_i = 16'h0000;
  end
  // Released lines toggle so a stale value never looks valid
  always @(rd_en, rd_val) flash_dq_i = rd_en ? rd_val : ~flash_dq_i;
  always @(posedge reset_powerdown_n)
  begin
    mode_r = 8'hff;
    pend_r = 8'h00;
    stat_r = 8'h80;
    rb_low = 1'h0;
  end
  always @(start_busy)
  begin
    rb_low = 1'h1;
    #1000 rb_low = 1'h0;
  end
  // Latch on whichever of strobe or select rises first
  always @(flash_we_n, flash_ce_n)
  begin
    if (!flash_we_n && !flash_ce_n && reset_powerdown_n)
      armed = 1'h1;
    else if (armed)
    begin
      armed = 1'h0;
      if (pend_r == 8'h00 && (flash_dq_o[7:0] == 8'hc0 || flash_dq_o[7:0] == 8'h40))
        pend_r = flash_dq_o[7:0];
      else if (pend_r == 8'h00)
        mode_r = flash_dq_o[7:0];
      else
      begin
        if (pend_r == 8'h40)
          -> start_busy;
        else if (oa == 8'h80)
          otp_r[128] = otp_r[128] & flash_dq_o;
        else if (!otp_r[128][1])
          stat_r = stat_r | 8'h12;
        else
          otp_r[oa] = otp_r[oa] & flash_dq_o;
        pend_r = 8'h00;
      end
    end
  end
endmodule

// ===== sim/afc_host_props.sv
`timescale 1ns/100ps
module afc_host_props #(
  parameter int ADDR_W = 22
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Flash pins
  input wire logic [ADDR_W-1:0] flash_addr,
  input wire logic flash_ce_n,
  input wire logic flash_oe_n,
  input wire logic flash_we_n,
  input wire logic reset_powerdown_n,
  input wire logic [15:0] flash_dq_o,
  input wire logic flash_dq_oe
);
  logic [7:0] lo_r;
  logic [7:0] hi_r;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  sequence s_we_low; !flash_we_n [*7]; endsequence
  sequence s_oe_low; !flash_oe_n [*7]; endsequence
  // Saturating counts; lo_r starts at one in reset as the pin is already low
  always_ff @(posedge clk_sys)
  begin
    lo_r <= !rst_b ? 8'h01 : reset_powerdown_n ? 8'h00 : lo_r + {7'h0, lo_r != 8'hff};
    hi_r <= !reset_powerdown_n ? 8'h00 : hi_r + {7'h0, hi_r != 8'hff};
  end
  a_no_oe_we: assert property (flash_oe_n || flash_we_n) else $error("oe and we low together");
  a_read_pins: assert property (!flash_oe_n |-> !flash_ce_n && flash_we_n && !flash_dq_oe) else $error("bad read");
  a_write_pins: assert property (!flash_we_n |-> !flash_ce_n && flash_oe_n && flash_dq_oe) else $error("bad write");
  a_reset_len: assert property ($rose(reset_powerdown_n) |-> lo_r >= afc_pkg::RESET_LOW_CYC) else $error("short");
  a_wake_read: assert property (!flash_oe_n |-> hi_r >= afc_pkg::WAKE_READ_CYC) else $error("read early");
  a_wake_write: assert property (!flash_we_n |-> hi_r >= afc_pkg::WAKE_WRITE_CYC) else $error("write early");
  a_we_width: assert property ($fell(flash_we_n) |-> s_we_low) else $error("strobe short");
  a_oe_width: assert property ($fell(flash_oe_n) |-> s_oe_low) else $error("read short");
  a_latch_hold: assert property (!flash_we_n ##1 !flash_we_n |-> $stable(flash_addr) && $stable(flash_dq_o))
    else $error("write data moved");
endmodule

// ===== sim/afc_host_tb.sv
`timescale 1ns/100ps
module afc_host_tb;
  typedef struct packed {logic [3:0] op; logic [7:0] cmd; logic [15:0] addr; logic [15:0] data;} afc_row_t;
  // Read rows carry the expected word in data
  afc_row_t rows [16] = '{44'h0_00_1234_486e, 44'h1_00_0000_0070, 44'h0_00_0000_0080, 44'h1_00_0000_0090,
    44'h0_00_0080_fffe, 44'h2_c0_0010_1234, 44'h0_00_0010_1234, 44'h2_c0_0080_fffd, 44'h2_c0_0080_ffff,
    44'h0_00_0080_fffc, 44'h2_c0_0011_0000, 44'h0_00_0011_ffff, 44'h1_00_0000_0070, 44'h0_00_0000_0092,
    44'h1_00_0000_00ff, 44'h0_00_0055_5a0f};
  logic clk_sys, rst_b;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [21:0] flash_addr;
  logic [15:0] flash_dq_i, flash_dq_o;
  logic flash_ce_n, flash_oe_n, flash_we_n, reset_powerdown_n, flash_byte_n, flash_dq_oe, rb_low;
  wire logic ready_busy_n = !rb_low;
  int mismatches = 0;
  int samples_checked = 0;
  int cycles = 0;
  afc_host afc_host_i (.clk_sys, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .flash_addr,
    .flash_ce_n, .flash_oe_n, .flash_we_n, .reset_powerdown_n, .flash_byte_n, .flash_dq_i, .flash_dq_o,
    .flash_dq_oe, .ready_busy_n);
  afc_flash_model afc_flash_model_i (.flash_addr, .flash_ce_n, .flash_oe_n, .flash_we_n, .reset_powerdown_n,
    .flash_byte_n, .flash_dq_o, .flash_dq_i, .rb_low);
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do
    begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end
    while (s_axi_bvalid !== 1'h1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do
    begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end
    while (s_axi_rvalid !== 1'h1);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask
  task automatic idle();
    repeat (2) @(posedge clk_sys);
    do rdr(afc_pkg::REG_STATUS);
    while (rd[afc_pkg::STAT_BUSY_BIT] !== 1'h0);
  endtask
  task automatic go(input logic [3:0] op, input logic [7:0] cmd, input logic [15:0] a, input logic [15:0] d,
    input logic byte_w);
    wr(afc_pkg::REG_ADDR, {16'h0000, a});
    wr(afc_pkg::REG_WDATA, {16'h0000, d});
    wr(afc_pkg::REG_CTRL, {16'h0000, cmd, 3'h0, byte_w, 1'h0, op[1:0], 1'h1});
    check("bresp_ok", {30'h0, rsp}, {30'h0, afc_pkg::RESP_OKAY});
    idle();
  endtask
  initial
  begin
    clk_sys = 1'h0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Hang guard, far above the thousand or so cycles the run needs
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      mismatches++;
      results();
    end
  end
  initial
  begin
    {rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    repeat (6) @(posedge clk_sys);
    rst_b <= 1'h1;
    #1 check("rp", {31'h0, reset_powerdown_n}, 32'h0);
    rdr(afc_pkg::REG_STATUS);
    check("waking", {31'h0, rd[afc_pkg::STAT_RESET_BIT]}, 32'h1);
    idle();
    foreach (rows[i])
    begin
      go(rows[i].op, rows[i].cmd, rows[i].addr, rows[i].data, 1'h1);
      if (rows[i].op == 4'h0)
      begin
        rdr(afc_pkg::REG_RDATA);
        check("rdata", rd & 32'hffff, {16'h0, rows[i].data});
      end
      if (rows[i].op == 4'h2)
      begin
        rdr(afc_pkg::REG_STATUS);
        check("lock_seq", {31'h0, rd[afc_pkg::STAT_PROT_BIT]}, {31'h0, rows[i].cmd == afc_pkg::CMD_OTP_PROG &&
          rows[i].addr == 16'h0080 && rows[i].data == afc_pkg::OTP_LOCK_DATA});
      end
    end
    go(4'h0, 8'h00, 16'h0055, 16'h0000, 1'h0);
    check("byte_n", {31'h0, flash_byte_n}, 32'h0);
    rdr(afc_pkg::REG_RDATA);
    check("byte", rd & 32'hff, 32'h0f);
    wr(8'h40, 32'h0);
    check("bresp", {30'h0, rsp}, {30'h0, afc_pkg::RESP_SLVERR});
    rdr(8'h44);
    check("rresp", {30'h0, rsp}, {30'h0, afc_pkg::RESP_SLVERR});
    // Long device operation, then a reset pulse that cuts it short
    go(4'h2, 8'h40, 16'h0005, 16'h1111, 1'h1);
    rdr(afc_pkg::REG_STATUS);
    check("rb", {31'h0, rd[afc_pkg::STAT_RB_BIT]}, 32'h1);
    go(4'h3, 8'h00, 16'h0000, 16'h0000, 1'h1);
    rdr(afc_pkg::REG_STATUS);
    check("rb", {31'h0, rd[afc_pkg::STAT_RB_BIT]}, 32'h0);
    go(4'h1, 8'h00, 16'h0000, 16'h0070, 1'h1);
    go(4'h0, 8'h00, 16'h0000, 16'h0000, 1'h1);
    rdr(afc_pkg::REG_RDATA);
    check("status", rd & 32'hffff, 32'h80);
    results();
  end
endmodule
bind afc_host afc_host_props #(.ADDR_W(ADDR_W)) afc_host_props_i (.clk_sys, .rst_b, .flash_addr, .flash_ce_n,
  .flash_oe_n, .flash_we_n, .reset_powerdown_n, .flash_dq_o, .flash_dq_oe);

// ===== verilog/afc_host.sv
// Contract
// - Host holds reset_powerdown_n low for at least 100 ns.
// - Host waits reset-to-output-valid time before trusting read data.
// - Host waits reset-to-write time before writing any command.
// - Flash reset is driven from the same reset as the processor.
// - Command 90H selects one-time block reads; FFH returns to array.
// - One-time programming is C0H, then one write with address and data.
// - Lock the one-time block with C0H, then FFFDH at address 80H.
// - Host gives block address for block commands, any address otherwise.
// - Host never drives output enable and write strobe low together.
`timescale 1ns/100ps
module afc_host #(
  parameter int ADDR_W = 22
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // AXI4-Lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Flash pins
  output logic [ADDR_W-1:0] flash_addr,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  output logic reset_powerdown_n,
  output logic flash_byte_n,
  input wire logic [15:0] flash_dq_i,
  output logic [15:0] flash_dq_o,
  output logic flash_dq_oe,
  input wire logic ready_busy_n
);
  if (ADDR_W < 8 || ADDR_W > 22)
  begin
    $error("ADDR_W out of range");
  end

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RST = 3'b001,
    ST_WAKE = 3'b010,
    ST_RD = 3'b011,
    ST_WR = 3'b100,
    ST_WR_END = 3'b101,
    ST_GAP = 3'b110
  } afc_state_t;

  afc_state_t state_r, state_nxt;
  logic [afc_pkg::CNT_W-1:0] cnt_r;
  logic [31:0] ctrl_r;
  logic [ADDR_W-1:0] addr_r;
  logic [15:0] wdata_r, rdata_r;
  logic second_r;
  logic awake_r;
  logic [7:0] last_cmd_r;
  logic rb_sync, rb_sync_n;
  logic [15:0] dq_sync;

  // Ready/busy floats high via pull-up; sampled through two flops
  afc_sync #(.WIDTH(1)) u_rb_sync (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .async_in(ready_busy_n),
    .sync_out(rb_sync_n)
  );
  assign rb_sync = ~rb_sync_n;
  // Data bus stands for the whole read phase, so two flops of delay cost nothing
  afc_sync #(.WIDTH(16)) u_dq_sync (
    .clk_sys(clk_sys), .rst_b(rst_b), .async_in(flash_dq_i), .sync_out(dq_sync)
  );

  // AXI write path: both channels accepted together while no response is pending
  wire wr_fire = s_axi_awvalid && s_axi_wvalid && s_axi_awready && s_axi_wready;
  wire rd_fire = s_axi_arvalid && s_axi_arready;
  wire busy = (state_r != ST_IDLE);
  wire hit_ctrl = (s_axi_awaddr == afc_pkg::REG_CTRL);
  wire hit_addr = (s_axi_awaddr == afc_pkg::REG_ADDR);
  wire hit_wdata = (s_axi_awaddr == afc_pkg::REG_WDATA);
  wire wr_ok = hit_ctrl || hit_addr || hit_wdata;
  wire go = wr_fire && hit_ctrl && s_axi_wstrb[0] && s_axi_wdata[afc_pkg::CTRL_GO_BIT] && !busy;
  wire [1:0] go_op = s_axi_wdata[afc_pkg::CTRL_OP_LSB +: afc_pkg::CTRL_OP_W];
  wire [1:0] cur_op = ctrl_r[afc_pkg::CTRL_OP_LSB +: afc_pkg::CTRL_OP_W];
  wire [7:0] cur_cmd = ctrl_r[afc_pkg::CTRL_CMD_LSB +: 8];
  wire cnt_done = (cnt_r == '0);

  // Lock write detection for status: C0H then FFFDH at 80H
  wire lock_seq = (last_cmd_r == afc_pkg::CMD_OTP_PROG) && (addr_r == afc_pkg::OTP_LOCK_ADDR[ADDR_W-1:0])
    && (wdata_r == afc_pkg::OTP_LOCK_DATA);

  wire [31:0] status_w = {26'h0, 1'b0, lock_seq & second_r, 1'b0, !awake_r, rb_sync, busy};
  wire [31:0] rd_mux = (s_axi_araddr == afc_pkg::REG_CTRL) ? ctrl_r :
    (s_axi_araddr == afc_pkg::REG_ADDR) ? 32'(addr_r) :
    (s_axi_araddr == afc_pkg::REG_WDATA) ? {16'h0, wdata_r} :
    (s_axi_araddr == afc_pkg::REG_STATUS) ? status_w :
    (s_axi_araddr == afc_pkg::REG_RDATA) ? {16'h0, rdata_r} : 32'h0;
  wire rd_ok = (s_axi_araddr <= afc_pkg::REG_RDATA) && (s_axi_araddr[1:0] == 2'b00);

  // Sequencer
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
      begin
        if (go)
        begin
          if (go_op == afc_pkg::OP_RESET)
            state_nxt = ST_RST;
          else if (go_op == afc_pkg::OP_READ)
            state_nxt = ST_RD;
          else
            state_nxt = ST_WR;
        end
      end
      ST_RST: if (cnt_done) state_nxt = ST_WAKE;
      ST_WAKE: if (cnt_done) state_nxt = ST_IDLE;
      ST_RD: if (cnt_done) state_nxt = ST_GAP;
      ST_WR: if (cnt_done) state_nxt = ST_WR_END;
      ST_WR_END: state_nxt = ST_GAP;
      ST_GAP:
      begin
        if (cnt_done)
          state_nxt = (cur_op == afc_pkg::OP_CMD2 && !second_r) ? ST_WR : ST_IDLE;
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // Reset-time wait, asserted from system reset too
  wire [afc_pkg::CNT_W-1:0] cnt_load =
    (state_nxt == ST_RST) ? afc_pkg::CNT_W'(afc_pkg::RESET_LOW_CYC - 1) :
    (state_nxt == ST_WAKE) ? afc_pkg::CNT_W'((afc_pkg::WAKE_READ_CYC > afc_pkg::WAKE_WRITE_CYC ?
      afc_pkg::WAKE_READ_CYC : afc_pkg::WAKE_WRITE_CYC) - 1) : afc_pkg::CNT_W'(afc_pkg::PHASE_CYC - 1);

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      state_r <= ST_RST;
      cnt_r <= afc_pkg::CNT_W'(afc_pkg::RESET_LOW_CYC - 1);
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= (state_nxt != state_r) ? cnt_load : (cnt_done ? cnt_r : cnt_r - 1'b1);
    end
  end

  // Register file
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      ctrl_r <= 32'h0;
      addr_r <= '0;
      wdata_r <= 16'h0;
    end
    else if (wr_fire)
    begin
      if (hit_ctrl && !busy)
        ctrl_r <= s_axi_wdata & ~(32'h1 << afc_pkg::CTRL_GO_BIT);
      else if (hit_addr && !busy)
        addr_r <= s_axi_wdata[ADDR_W-1:0];
      else if (hit_wdata && !busy)
        wdata_r <= s_axi_wdata[15:0];
    end
  end

  // Device state tracking
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      second_r <= 1'b0;
      awake_r <= 1'b0;
      last_cmd_r <= afc_pkg::CMD_READ_ARRAY;
      rdata_r <= 16'h0;
    end
    else
    begin
      if (state_r == ST_RST)
        awake_r <= 1'b0;
      else if (state_r == ST_WAKE && cnt_done)
        awake_r <= 1'b1;
      if (go)
        second_r <= 1'b0;
      else if (state_r == ST_GAP && cnt_done && cur_op == afc_pkg::OP_CMD2)
        second_r <= 1'b1;
      if (state_r == ST_WR_END && !second_r)
        last_cmd_r <= cur_cmd;
      if (state_r == ST_RD && cnt_done)
        rdata_r <= ctrl_r[afc_pkg::CTRL_BYTE_BIT] ? dq_sync : {8'h00, dq_sync[7:0]};
    end
  end

  // Pins, all from flops
  wire wr_phase = (state_nxt == ST_WR);
  wire rd_phase = (state_nxt == ST_RD);
  // Command byte taken from the bus at the start edge, as ctrl_r loads on that same edge
  wire [15:0] wr_val = (state_r == ST_IDLE && go_op == afc_pkg::OP_CMD2) ?
    {8'h00, s_axi_wdata[afc_pkg::CTRL_CMD_LSB +: 8]} : wdata_r;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      reset_powerdown_n <= 1'b0;
      flash_ce_n <= 1'b1;
      flash_oe_n <= 1'b1;
      flash_we_n <= 1'b1;
      flash_dq_oe <= 1'b0;
      flash_dq_o <= 16'h0;
      flash_addr <= '0;
      flash_byte_n <= 1'b1;
    end
    else
    begin
      reset_powerdown_n <= (state_nxt != ST_RST);
      flash_ce_n <= !(wr_phase || rd_phase);
      flash_oe_n <= !rd_phase;
      flash_we_n <= !wr_phase;
      flash_dq_oe <= wr_phase;
      if (wr_phase && state_r != ST_WR)
        flash_dq_o <= wr_val;
      flash_addr <= addr_r;
      flash_byte_n <= go ? s_axi_wdata[afc_pkg::CTRL_BYTE_BIT] : ctrl_r[afc_pkg::CTRL_BYTE_BIT];
    end
  end

  // Ready a cycle after valid; the response only follows the handshake
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= afc_pkg::RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= afc_pkg::RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= s_axi_awvalid && s_axi_wvalid && !s_axi_wready && !s_axi_bvalid;
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? afc_pkg::RESP_OKAY : afc_pkg::RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (rd_fire)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_ok ? rd_mux : 32'h0;
        s_axi_rresp <= rd_ok ? afc_pkg::RESP_OKAY : afc_pkg::RESP_SLVERR;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// ===== verilog/afc_pkg.sv
package afc_pkg;
  // Register offsets (byte addresses)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_RDATA = 8'h10;
  // Control fields
  localparam int CTRL_GO_BIT = 0;
  localparam int CTRL_OP_LSB = 1;
  localparam int CTRL_OP_W = 2;
  localparam int CTRL_RESET_BIT = 3;
  localparam int CTRL_BYTE_BIT = 4;
  localparam int CTRL_CMD_LSB = 8;
  // Status fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_RB_BIT = 1;
  localparam int STAT_RESET_BIT = 2;
  localparam int STAT_PFAIL_BIT = 3;
  localparam int STAT_PROT_BIT = 4;
  // Bus response codes
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // Operation codes
  localparam logic [1:0] OP_READ = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_CMD2 = 2'h2;
  localparam logic [1:0] OP_RESET = 2'h3;
  // Device commands and values
  localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
  localparam logic [7:0] CMD_READ_ID = 8'h90;
  localparam logic [7:0] CMD_OTP_PROG = 8'hc0;
  localparam logic [15:0] OTP_LOCK_DATA = 16'hfffd;
  localparam logic [21:0] OTP_LOCK_ADDR = 22'h000080;
  localparam int PFAIL_SR_BIT = 4;
  localparam int PROT_SR_BIT = 1;
  // Timing (ns) and cycle counts at 100 MHz
  localparam int CLK_PERIOD_NS = 10;
  localparam int RESET_LOW_NS = 100;
  localparam int RESET_LOW_CYC = (RESET_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_READ_NS = 150;
  localparam int WAKE_READ_CYC = (WAKE_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_WRITE_NS = 150;
  localparam int WAKE_WRITE_CYC = (WAKE_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PHASE_NS = 70;
  localparam int PHASE_CYC = (PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 8;
endpackage

// ===== verilog/afc_sync.sv
`timescale 1ns/100ps
module afc_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Level in and out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      meta_r <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule
